// File: hdl/bst_pkg.sv
// Constants for the boundary scan test access port.
// Assumes a tester-driven test clock separate from the system clock.
package bst_pkg;

  // ==========================================================
  // Sizes
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int USER_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Instruction opcodes
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] OP_USER = 4'h8;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;

  // ==========================================================
  // Capture and reset values
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
  // Arbitrary neutral identity, bit 0 set as the scan standard demands
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001;
  localparam int TLR_TMS_EDGES = 5;

  // ==========================================================
  // TAP controller states
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
    EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
  } bst_state_e;

endpackage

// File: hdl/bst_fifo.sv
// Word FIFO with a registered output stage.
// Assumes one clock; both sides use valid/ready.
module bst_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Filling side
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Draining side
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("bst_fifo DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign inReady = (cnt_r != CW'(DEPTH));
  assign push = inValid && inReady;
  // Refill the output stage whenever it empties or is taken
  assign pop = (cnt_r != '0) && (!outValid || outReady);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + AW'(1);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr_r];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

  full_cov_c: cover property (@(posedge clk) disable iff (!rst_b) !inReady);
endmodule

// File: hdl/bst_tap.sv
// Boundary scan test access port with a user data register whose
// updates cross to the system clock and queue in a FIFO.
// Assumes the tester drives tck, tms, tdi and trst_b; tdo is three-state.
//
// How it works
// - TDI shifts into instruction or data path on rising test clock in shift states.
// - TDO takes the next bit on each falling test clock edge while shifting.
// - Tester sets TMS before rising edge; device samples it there for next state.
// - Test reset forces the controller to its reset state at once, no clock needed.
// - All scan state and data are timed by the tester's clock, not system clock.
// - Controller, instructions and serial paths follow the boundary scan standard.
// - TDO floats in every state but data shift and instruction shift.
module bst_tap #(
  parameter logic [bst_pkg::ID_W-1:0] ID_CODE = bst_pkg::ID_DEFAULT,
  parameter int USER_W = bst_pkg::USER_W,
  parameter int DEPTH = bst_pkg::FIFO_DEPTH
) (
  // System side
  input wire logic sys_clk,
  input wire logic rst_b,
  output logic [USER_W-1:0] wordData,
  output logic wordValid,
  input wire logic wordReady,
  // Test port
  input wire logic tck,
  input wire logic trst_b,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOe
);
  localparam int IRW = bst_pkg::IR_W;
  localparam int IDW = bst_pkg::ID_W;

  if (USER_W < 1 || ID_CODE[0] != 1'b1) begin : g_chk
    $error("bst_tap needs USER_W >= 1 and ID_CODE bit 0 set");
  end

  // ==========================================================
  // Controller
  function automatic bst_pkg::bst_state_e stepTap(bst_pkg::bst_state_e s, logic m);
    case (s)
      bst_pkg::TLR: stepTap = m ? bst_pkg::TLR : bst_pkg::RTI;
      bst_pkg::RTI: stepTap = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_DR: stepTap = m ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
      bst_pkg::CAP_DR: stepTap = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::SH_DR: stepTap = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::EX1_DR: stepTap = m ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
      bst_pkg::PAU_DR: stepTap = m ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
      bst_pkg::EX2_DR: stepTap = m ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
      bst_pkg::UPD_DR: stepTap = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_IR: stepTap = m ? bst_pkg::TLR : bst_pkg::CAP_IR;
      bst_pkg::CAP_IR: stepTap = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::SH_IR: stepTap = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::EX1_IR: stepTap = m ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
      bst_pkg::PAU_IR: stepTap = m ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
      bst_pkg::EX2_IR: stepTap = m ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
      bst_pkg::UPD_IR: stepTap = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      default: stepTap = bst_pkg::TLR;
    endcase
  endfunction

  bst_pkg::bst_state_e state_r;
  logic [IRW-1:0] irShift_r;
  logic [IRW-1:0] instr_r;
  logic bypass_r;
  logic [IDW-1:0] idShift_r;
  logic [USER_W-1:0] userShift_r;
  logic [USER_W-1:0] xferWord_r;
  logic reqTgl_r;
  logic ackS1_r;
  logic ackS2_r;
  logic pending;
  logic shifting;
  logic serialOut;

  assign pending = reqTgl_r != ackS2_r;
  assign shifting = (state_r == bst_pkg::SH_DR) || (state_r == bst_pkg::SH_IR);

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      state_r <= bst_pkg::TLR;
    end else begin
      state_r <= stepTap(state_r, tms);
    end
  end

  // ==========================================================
  // Instruction register
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      irShift_r <= bst_pkg::IR_CAPTURE;
      instr_r <= bst_pkg::IR_RESET;
    end else begin
      case (state_r)
        bst_pkg::TLR: instr_r <= bst_pkg::IR_RESET;
        bst_pkg::CAP_IR: irShift_r <= bst_pkg::IR_CAPTURE;
        bst_pkg::SH_IR: irShift_r <= {tdi, irShift_r[IRW-1:1]};
        bst_pkg::UPD_IR: instr_r <= irShift_r;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Data registers
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      bypass_r <= 1'b0;
      idShift_r <= '0;
      userShift_r <= '0;
    end else if (state_r == bst_pkg::CAP_DR) begin
      bypass_r <= 1'b0;
      idShift_r <= ID_CODE;
      // Bit 0 tells the tester the previous word has not crossed yet
      userShift_r <= USER_W'(pending);
    end else if (state_r == bst_pkg::SH_DR) begin
      bypass_r <= tdi;
      idShift_r <= {tdi, idShift_r[IDW-1:1]};
      userShift_r <= {tdi, userShift_r[USER_W-1:1]};
    end
  end

  // ==========================================================
  // Word handoff to the system clock
  // An update while the last word is still in flight is dropped; the
  // scan clock cannot be stalled, so the pending bit is the back-pressure.
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      xferWord_r <= '0;
      reqTgl_r <= 1'b0;
    end else if (state_r == bst_pkg::UPD_DR && instr_r == bst_pkg::OP_USER && !pending) begin
      xferWord_r <= userShift_r;
      reqTgl_r <= !reqTgl_r;
    end
  end

  logic reqS1_r;
  logic reqS2_r;
  logic ackTgl_r;
  logic fifoReady;
  logic fifoValid;

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
    end else begin
      ackS1_r <= ackTgl_r;
      ackS2_r <= ackS1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      ackTgl_r <= 1'b0;
    end else begin
      reqS1_r <= reqTgl_r;
      reqS2_r <= reqS1_r;
      if (fifoValid && fifoReady) begin
        ackTgl_r <= reqS2_r;
      end
    end
  end

  assign fifoValid = reqS2_r != ackTgl_r;

  bst_fifo #(.W(USER_W), .DEPTH(DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .inData(xferWord_r),
    .inValid(fifoValid),
    .inReady(fifoReady),
    .outData(wordData),
    .outValid(wordValid),
    .outReady(wordReady)
  );

  // ==========================================================
  // Serial output on the falling edge
  always_comb begin
    serialOut = bypass_r;
    if (state_r == bst_pkg::SH_IR) begin
      serialOut = irShift_r[0];
    end else begin
      case (instr_r)
        bst_pkg::OP_IDCODE: serialOut = idShift_r[0];
        bst_pkg::OP_USER: serialOut = userShift_r[0];
        default: serialOut = bypass_r;
      endcase
    end
  end

  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
    end else begin
      tdoOe <= shifting;
      if (shifting) begin
        tdo <= serialOut;
      end
    end
  end

  // ==========================================================
  // Checks
  logic ackSeen_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackSeen_r <= 1'b0;
    end else begin
      ackSeen_r <= fifoValid && fifoReady;
    end
  end

  reset_state_a: assert property (@(posedge tck) !trst_b |-> state_r == bst_pkg::TLR)
    else $error("controller not in reset during test reset");
  tms_reset_a: assert property (@(posedge tck) disable iff (!trst_b) tms [*5] |=> state_r == bst_pkg::TLR)
    else $error("five high mode edges did not reach reset");
  tms_step_a: assert property (@(posedge tck) disable iff (!trst_b)
    state_r == bst_pkg::RTI && !tms |=> state_r == bst_pkg::RTI ##0 $past(tms) == 1'b0)
    else $error("idle state left with mode low");
  ir_shift_a: assert property (@(posedge tck) disable iff (!trst_b)
    state_r == bst_pkg::SH_IR |=> irShift_r[IRW-1] == $past(tdi))
    else $error("instruction shift lost input bit");
  dr_shift_a: assert property (@(posedge tck) disable iff (!trst_b)
    state_r == bst_pkg::SH_DR |=> bypass_r == $past(tdi))
    else $error("bypass bit did not take input");
  tdo_float_a: assert property (@(posedge tck) disable iff (!trst_b) tdoOe == shifting)
    else $error("output enable outside shift states");
  tdo_value_a: assert property (@(posedge tck) disable iff (!trst_b)
    state_r == bst_pkg::SH_IR && $past(state_r) == bst_pkg::SH_IR |-> tdo == irShift_r[0])
    else $error("serial output not updated on falling edge");
  ir_update_a: assert property (@(posedge tck) disable iff (!trst_b)
    state_r == bst_pkg::UPD_IR |=> instr_r == $past(irShift_r))
    else $error("instruction not updated");
  word_cross_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fifoValid && fifoReady |=> !fifoValid ##0 ackSeen_r)
    else $error("handed word not acknowledged");

  idcode_c: cover property (@(posedge tck) disable iff (!trst_b)
    instr_r == bst_pkg::OP_IDCODE && state_r == bst_pkg::SH_DR);
  bypass_c: cover property (@(posedge tck) disable iff (!trst_b)
    instr_r == bst_pkg::OP_BYPASS && state_r == bst_pkg::SH_DR);
  user_xfer_c: cover property (@(posedge sys_clk) disable iff (!rst_b) wordValid && wordReady);
endmodule

// File: sim/bst_tester.sv
// Tester model for the scan port; the test clock runs only while the step task is pulsing it.
// Assumes the bench resolves the three-state data-out line into tdoLine.
module bst_tester (
  // Test port
  output logic tck,
  output logic trst_b,
  output logic tms,
  output logic tdi,
  input wire logic tdoLine
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    tck = 1'b0;
    trst_b = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic hold_reset(input logic v);
    trst_b = v;
  endtask

  // ==========================================================
  // One 80 ns period; inputs settle half a period before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40;
    o = tdoLine;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask

  task automatic go_idle();
    logic o;
    repeat (bst_pkg::TLR_TMS_EDGES) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  // ==========================================================
  // Whole scan from idle, LSB first; idle edges give the crossing time
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    repeat (4) step(1'b0, 1'b1, o);
  endtask
endmodule

// File: sim/bst_tap_bench.sv
// Bench for the scan port: scans through the tester model, checks words on the system side.
// Assumes the design package and the tester model are compiled first.
module bst_tap_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wordReady = 1'b0;
  logic drainOn = 1'b0;
  logic [7:0] wordData;
  logic wordValid, tck, trst_b, tms, tdi, tdo, tdoOe, tdoLine;
  logic [7:0] qExp[$];
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'hFD82;

  always #4 sys_clk = ~sys_clk;
  // Released line shows the inverse of its last level
  assign tdoLine = tdoOe ? tdo : ~tdo;

  bst_tap u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .wordData(wordData), .wordValid(wordValid),
    .wordReady(wordReady), .tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
  bst_tester u_tst (.tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // System side: random stalls, oldest note compared on each take
  always @(posedge sys_clk) begin
    #1 wordReady = drainOn ? 1'($random(seed)) : 1'b0;
  end

  always @(posedge sys_clk) begin
    if (wordValid === 1'b1 && wordReady === 1'b1) begin
      if (qExp.size() == 0) check("extra word", 32'h0, 32'h1);
      else check("word", 32'(qExp.pop_front()), 32'(wordData));
    end
  end

  initial begin
    #400us;
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] cap;
    logic [7:0] w;
    logic b;
    logic [3:0] ops[3];
    ops = '{bst_pkg::OP_EXTEST, bst_pkg::OP_BYPASS, 4'h3};
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    u_tst.hold_reset(1'b1);
    check("valid after reset", 32'h0, 32'(wordValid));
    check("oe after reset", 32'h0, 32'(tdoOe));
    u_tst.go_idle();
    u_tst.scan(1'b0, 32, 32'h0, cap);
    check("id after reset", bst_pkg::ID_DEFAULT, cap);
    u_tst.scan(1'b1, 4, 32'(bst_pkg::OP_USER), cap);
    check("ir capture", 32'(bst_pkg::IR_CAPTURE), cap);
    // Stalled: 32 queued, one in the output stage, one held; the last is dropped
    for (int i = 0; i < 35; i++) begin
      w = 8'($random(seed));
      u_tst.scan(1'b0, 8, 32'(w), cap);
      check("busy flag", 32'(i == 34), cap);
      if (i < 34) qExp.push_back(w);
    end
    check("oe idle", 32'h0, 32'(tdoOe));
    drainOn = 1'b1;
    for (int k = 0; k < 3000 && qExp.size() > 0; k++) @(posedge sys_clk);
    check("words left", 32'h0, 32'(qExp.size()));
    foreach (ops[j]) begin
      u_tst.scan(1'b1, 4, 32'(ops[j]), cap);
      w = 8'($random(seed));
      u_tst.scan(1'b0, 8, 32'(w), cap);
      check("bypass", 32'({w[6:0], 1'b0}), cap);
    end
    u_tst.go_idle();
    u_tst.scan(1'b0, 32, 32'h0, cap);
    check("id after tms reset", bst_pkg::ID_DEFAULT, cap);
    u_tst.scan(1'b1, 4, 32'(bst_pkg::OP_BYPASS), cap);
    u_tst.step(1'b1, 1'b1, b);
    u_tst.step(1'b0, 1'b1, b);
    u_tst.step(1'b0, 1'b1, b);
    #1 check("oe in shift", 32'h1, 32'(tdoOe));
    // Test reset with the clock standing still
    u_tst.hold_reset(1'b0);
    #1 check("oe on test reset", 32'h0, 32'(tdoOe));
    // Clock runs while held: the controller must stay in reset
    u_tst.step(1'b0, 1'b1, b);
    #1 check("oe held in reset", 32'h0, 32'(tdoOe));
    u_tst.hold_reset(1'b1);
    u_tst.step(1'b0, 1'b1, b);
    u_tst.scan(1'b0, 32, 32'h0, cap);
    check("id after test reset", bst_pkg::ID_DEFAULT, cap);
    tally_and_finish();
  end
endmodule
